// >>> src/capcmp_regs.vh
// Register offsets, field positions and reset values for the capture/compare channels
`ifndef CAPCMP_REGS_VH
`define CAPCMP_REGS_VH
`define ADDR_CAP_CTRL    4'h0
`define ADDR_CAP_DATA    4'h1
`define ADDR_CMP_CTRL    4'h2
`define ADDR_CMP_PRI     4'h3
`define ADDR_CMP_SEC     4'h4
`define CTRL_RESET       16'h0000
`define BIT_IDLE_STOP    13
`define BIT_CAP_TSEL     7
`define BIT_CAP_CPI_HI   6
`define BIT_CAP_CPI_LO   5
`define BIT_CAP_OVF      4
`define BIT_CAP_BNE      3
`define BIT_CMP_FLT      4
`define BIT_CMP_TSEL     3
`define CAP_OFF          3'h0
`define CAP_EVERY        3'h1
`define CAP_FALL         3'h2
`define CAP_RISE         3'h3
`define CAP_RISE4        3'h4
`define CAP_RISE16       3'h5
`define CAP_WAKE         3'h7
`define CMP_OFF          3'h0
`define CMP_HIGH_SHOT    3'h1
`define CMP_LOW_SHOT     3'h2
`define CMP_TOGGLE       3'h3
`define CMP_DELAY_SHOT   3'h4
`define CMP_PULSES       3'h5
`define CMP_PWM          3'h6
`define CMP_PWM_FLT      3'h7
`endif

// >>> src/capture_fifo.v
// Four-word capture buffer that refuses writes when full
`timescale 1ns/1ps
module capture_fifo
#(
   parameter WIDTH = 16,                  // Captured word width
   parameter AW    = 2                    // Log2 of depth
)
(
   input  wire             clk_sys_i,     // System clock
   input  wire             rst_i,         // Async reset, high
   input  wire             clr_i,         // Flush contents
   input  wire             wr_i,          // Push a word
   input  wire [WIDTH-1:0] wdata_i,       // Word to push
   input  wire             rd_i,          // Pop a word
   output wire [WIDTH-1:0] rdata_o,       // Oldest word
   output wire             full_o,        // Buffer full
   output wire             empty_o,       // Buffer empty
   output wire [AW:0]      level_o        // Words held
);
   reg [WIDTH-1:0] mem [0:(1<<AW)-1];     // Storage
   reg [AW-1:0]    wp_ff;                 // Write pointer
   reg [AW-1:0]    rp_ff;                 // Read pointer
   reg [AW:0]      cnt_ff;                // Fill count
   wire            do_wr;                 // Accepted push
   wire            do_rd;                 // Accepted pop

   assign full_o  = (cnt_ff == (1 << AW));
   assign empty_o = (cnt_ff == {(AW+1){1'b0}});
   assign level_o = cnt_ff;
   assign rdata_o = mem[rp_ff];
   // Full buffer keeps old words; new ones are dropped
   assign do_wr   = wr_i & ~full_o;
   assign do_rd   = rd_i & ~empty_o;

   // Storage has no reset, only pointers and count do
   always @(posedge clk_sys_i)
   begin
      if (do_wr)
         mem[wp_ff] <= wdata_i;
   end

   // Pointer and count upkeep
   always @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wp_ff  <= {AW{1'b0}};
         rp_ff  <= {AW{1'b0}};
         cnt_ff <= {(AW+1){1'b0}};
      end
      else if (clr_i)
      begin
         wp_ff  <= {AW{1'b0}};
         rp_ff  <= {AW{1'b0}};
         cnt_ff <= {(AW+1){1'b0}};
      end
      else
      begin
         if (do_wr)
            wp_ff <= wp_ff + 1'b1;
         if (do_rd)
            rp_ff <= rp_ff + 1'b1;
         if (do_wr & ~do_rd)
            cnt_ff <= cnt_ff + 1'b1;
         else if (do_rd & ~do_wr)
            cnt_ff <= cnt_ff - 1'b1;
      end
   end
endmodule

// >>> src/capture_compare_channels.v
// One input capture channel and one output compare channel with register port
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "capcmp_regs.vh"
module capture_compare_channels
#(
   parameter DMA_CAPABLE = 1              // Channel may raise DMA requests
)
(
   input  wire        clk_sys_i,          // System clock, 125 MHz
   input  wire        rst_i,              // Async reset, high
   input  wire [3:0]  addr_i,             // Register index
   input  wire [15:0] wdata_i,            // Write data
   input  wire        wr_i,               // Write strobe
   input  wire        rd_i,               // Read strobe
   output reg  [15:0] rdata_o,            // Read data, cycle after strobe
   input  wire [15:0] first_time_base_i,  // First timer count
   input  wire [15:0] second_time_base_i, // Second timer count
   input  wire        cpu_idle_i,         // CPU in idle
   input  wire        cpu_sleep_i,        // CPU in sleep
   input  wire        capture_input_pin_i,// Capture pin, asynchronous
   input  wire        compare_fault_input_i, // Fault pin, low active
   input  wire        pwm_period_i,       // Selected timer period rollover
   output reg         cap_irq_o,          // Capture interrupt pulse
   output reg         cap_dma_req_o,      // Capture DMA request pulse
   output reg         wake_o,             // Wake request pulse
   output reg         cmp_out_o,          // Compare pin level
   output reg         cmp_oe_o,           // Compare owns the pin
   output reg         cmp_irq_o           // Compare interrupt pulse
);
   // Control registers and compare values
   reg  [15:0] cap_ctrl_ff;               // Capture control, writable bits
   reg  [15:0] cmp_ctrl_ff;               // Compare control, writable bits
   reg  [15:0] compare_value_ff;          // Primary compare value
   reg  [15:0] cmp_sec_ff;                // Secondary compare value
   reg         cap_ovf_ff;                // Overflow flag
   reg         cmp_flt_ff;                // Fault flag
   // Pin synchronisers
   reg  [1:0]  cap_sync_ff;               // Capture pin synchroniser
   reg  [1:0]  flt_sync_ff;               // Fault pin synchroniser
   reg         cap_prev_ff;               // Last synced capture level
   reg         flt_prev_ff;               // Last synced fault level
   reg  [3:0]  pre_cnt_ff;                // Rising-edge prescaler
   reg  [1:0]  irq_cnt_ff;                // Captures since last interrupt
   reg         pop_ff;                    // Data read pending pop
   // Compare state
   reg         cmp_done_ff;               // One-shot finished
   reg  [2:0]  cmp_mode_prev_ff;          // Mode seen last cycle
   reg  [15:0] pwm_duty_ff;               // Latched duty value
   reg         nxt_out;                   // Next compare pin level
   reg         nxt_done;                  // Next one-shot state
   reg         nxt_cap;                   // Capture this cycle
   wire [2:0]  cap_mode;                  // Capture mode field
   wire [2:0]  cmp_mode;                  // Compare mode field
   wire [15:0] cap_time;                  // Selected capture count
   wire [15:0] cmp_time;                  // Selected compare count
   wire        rise;                      // Synced capture rising edge
   wire        fall;                      // Synced capture falling edge
   wire        cap_run;                   // Capture not halted
   wire        cmp_run;                   // Compare not halted
   wire        fifo_full;                 // Buffer full
   wire        fifo_empty;                // Buffer empty
   wire [15:0] fifo_data;                 // Oldest capture
   wire [2:0]  fifo_level;                // Words held
   wire        match_pri;                 // Primary match
   wire        match_sec;                 // Secondary match
   wire        flt_fall;                  // Fault falling edge
   wire [1:0]  cpi;                       // Captures per interrupt

   assign cap_mode = cap_ctrl_ff[2:0];
   assign cmp_mode = cmp_ctrl_ff[2:0];
   assign cpi      = cap_ctrl_ff[`BIT_CAP_CPI_HI:`BIT_CAP_CPI_LO];
   assign rise     = cap_sync_ff[1] & ~cap_prev_ff;
   assign fall     = ~cap_sync_ff[1] & cap_prev_ff;
   assign flt_fall = ~flt_sync_ff[1] & flt_prev_ff;
   // Idle stop halts the channel only while the CPU idles
   assign cap_run  = ~(cpu_idle_i & cap_ctrl_ff[`BIT_IDLE_STOP]);
   assign cmp_run  = ~(cpu_idle_i & cmp_ctrl_ff[`BIT_IDLE_STOP]);
   // Select bit 1 picks the first base for capture and the second base for compare
   assign cap_time = cap_ctrl_ff[`BIT_CAP_TSEL] ? first_time_base_i
                                                : second_time_base_i;
   assign cmp_time = cmp_ctrl_ff[`BIT_CMP_TSEL] ? second_time_base_i
                                                : first_time_base_i;
   assign match_pri = (cmp_time == compare_value_ff);
   assign match_sec = (cmp_time == cmp_sec_ff);

   // Capture event qualification by mode
   always @*
   begin
      nxt_cap = 1'b0;
      case (cap_mode)
         `CAP_EVERY:  nxt_cap = rise | fall;
         `CAP_FALL:   nxt_cap = fall;
         `CAP_RISE:   nxt_cap = rise;
         `CAP_RISE4:  nxt_cap = rise & (pre_cnt_ff[1:0] == 2'h3);
         `CAP_RISE16: nxt_cap = rise & (pre_cnt_ff == 4'hf);
         default:     nxt_cap = 1'b0;
      endcase
      nxt_cap = nxt_cap & cap_run;
   end

   capture_fifo
   #(
      .WIDTH (16),
      .AW    (2)
   )
   u_fifo
   (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .clr_i     (cap_mode == `CAP_OFF),
      .wr_i      (nxt_cap),
      .wdata_i   (cap_time),
      .rd_i      (pop_ff),
      .rdata_o   (fifo_data),
      .full_o    (fifo_full),
      .empty_o   (fifo_empty),
      .level_o   (fifo_level)
   );

   // Pin synchronisers: first stage feeds only the second
   always @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cap_sync_ff <= 2'h0;
         flt_sync_ff <= 2'h3;
         cap_prev_ff <= 1'b0;
         flt_prev_ff <= 1'b1;
      end
      else
      begin
         cap_sync_ff <= {cap_sync_ff[0], capture_input_pin_i};
         flt_sync_ff <= {flt_sync_ff[0], compare_fault_input_i};
         cap_prev_ff <= cap_sync_ff[1];
         flt_prev_ff <= flt_sync_ff[1];
      end
   end

   // Capture counters, flags and requests
   always @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pre_cnt_ff    <= 4'h0;
         irq_cnt_ff    <= 2'h0;
         cap_ovf_ff    <= 1'b0;
         cap_irq_o     <= 1'b0;
         cap_dma_req_o <= 1'b0;
         wake_o        <= 1'b0;
      end
      else
      begin
         cap_irq_o     <= 1'b0;
         cap_dma_req_o <= 1'b0;
         wake_o        <= 1'b0;
         // Prescaler only runs in prescaled modes
         if (cap_mode != `CAP_RISE4 && cap_mode != `CAP_RISE16)
            pre_cnt_ff <= 4'h0;
         else if (rise & cap_run)
            pre_cnt_ff <= pre_cnt_ff + 4'h1;
         if (cap_mode == `CAP_OFF)
         begin
            irq_cnt_ff <= 2'h0;
            cap_ovf_ff <= 1'b0;
         end
         else if (cap_mode == `CAP_WAKE)
         begin
            // Wake source only while asleep or idle
            if (rise & (cpu_sleep_i | cpu_idle_i))
            begin
               wake_o    <= 1'b1;
               cap_irq_o <= 1'b1;
            end
         end
         else if (nxt_cap)
         begin
            // Overflow is sticky; hardware clears it once the buffer drains
            if (fifo_full)
               cap_ovf_ff <= 1'b1;
            if (cpu_sleep_i | cpu_idle_i)
               wake_o <= 1'b1;
            if (DMA_CAPABLE != 0 && cpi == 2'h0)
               cap_dma_req_o <= 1'b1;
            if (cap_mode == `CAP_EVERY || irq_cnt_ff == cpi)
            begin
               cap_irq_o  <= 1'b1;
               irq_cnt_ff <= 2'h0;
            end
            else
               irq_cnt_ff <= irq_cnt_ff + 2'h1;
         end
         else if (fifo_empty)
            cap_ovf_ff <= 1'b0;
      end
   end

   // Compare output sequencing
   always @*
   begin
      nxt_out  = cmp_out_o;
      nxt_done = cmp_done_ff;
      if (cmp_mode != cmp_mode_prev_ff)
      begin
         // Entry level for the freshly written mode
         nxt_done = 1'b0;
         case (cmp_mode)
            `CMP_HIGH_SHOT:  nxt_out = 1'b0;
            `CMP_LOW_SHOT:   nxt_out = 1'b1;
            `CMP_TOGGLE:     nxt_out = cmp_out_o;
            `CMP_DELAY_SHOT: nxt_out = 1'b0;
            `CMP_PULSES:     nxt_out = 1'b0;
            `CMP_PWM:        nxt_out = (compare_value_ff != 16'h0000);
            `CMP_PWM_FLT:    nxt_out = (compare_value_ff != 16'h0000);
            default:         nxt_out = 1'b0;
         endcase
      end
      else if (cmp_run)
      begin
         case (cmp_mode)
            `CMP_HIGH_SHOT:  if (match_pri) nxt_out = 1'b1;
            `CMP_LOW_SHOT:   if (match_pri) nxt_out = 1'b0;
            `CMP_TOGGLE:     if (match_pri) nxt_out = ~cmp_out_o;
            `CMP_DELAY_SHOT:
            begin
               if (match_pri & ~cmp_done_ff)
                  nxt_out = 1'b1;
               else if (match_sec & cmp_out_o)
               begin
                  nxt_out  = 1'b0;
                  nxt_done = 1'b1;
               end
            end
            `CMP_PULSES:
            begin
               if (match_pri)
                  nxt_out = 1'b1;
               else if (match_sec)
                  nxt_out = 1'b0;
            end
            `CMP_PWM, `CMP_PWM_FLT:
            begin
               if (cmp_mode == `CMP_PWM_FLT && (cmp_flt_ff | flt_fall))
                  nxt_out = 1'b0;
               else if (pwm_period_i)
                  nxt_out = (compare_value_ff != 16'h0000);
               else if (cmp_time == pwm_duty_ff)
                  nxt_out = 1'b0;
            end
            default:         nxt_out = 1'b0;
         endcase
      end
   end

   // Compare registers, interrupts and fault flag
   always @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cmp_out_o        <= 1'b0;
         cmp_oe_o         <= 1'b0;
         cmp_irq_o        <= 1'b0;
         cmp_done_ff      <= 1'b0;
         cmp_mode_prev_ff <= `CMP_OFF;
         cmp_flt_ff       <= 1'b0;
         pwm_duty_ff      <= 16'h0000;
      end
      else
      begin
         cmp_out_o        <= nxt_out;
         cmp_done_ff      <= nxt_done;
         cmp_mode_prev_ff <= cmp_mode;
         cmp_oe_o         <= (cmp_mode != `CMP_OFF);
         // Duty reloads at period so each period is glitch free
         if (pwm_period_i | (cmp_mode != cmp_mode_prev_ff))
            pwm_duty_ff <= compare_value_ff;
         // Fault flag clears only by hardware, on leaving fault mode
         if (cmp_mode == `CMP_PWM_FLT && flt_fall)
            cmp_flt_ff <= 1'b1;
         else if (cmp_mode != `CMP_PWM_FLT)
            cmp_flt_ff <= 1'b0;
         cmp_irq_o <= 1'b0;
         if (cmp_mode_prev_ff == cmp_mode)
         begin
            case (cmp_mode)
               `CMP_HIGH_SHOT:  cmp_irq_o <= nxt_out & ~cmp_out_o;
               `CMP_LOW_SHOT:   cmp_irq_o <= ~nxt_out & cmp_out_o;
               `CMP_TOGGLE:     cmp_irq_o <= nxt_out ^ cmp_out_o;
               `CMP_DELAY_SHOT: cmp_irq_o <= ~nxt_out & cmp_out_o;
               `CMP_PULSES:     cmp_irq_o <= ~nxt_out & cmp_out_o;
               `CMP_PWM_FLT:    cmp_irq_o <= flt_fall;
               default:         cmp_irq_o <= 1'b0;
            endcase
         end
      end
   end

   // Register writes; software must stop the timer first
   always @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cap_ctrl_ff      <= `CTRL_RESET;
         cmp_ctrl_ff      <= `CTRL_RESET;
         compare_value_ff <= 16'h0000;
         cmp_sec_ff       <= 16'h0000;
      end
      else if (wr_i)
      begin
         case (addr_i)
            `ADDR_CAP_CTRL: cap_ctrl_ff <= wdata_i & 16'h20e7;
            `ADDR_CMP_CTRL: cmp_ctrl_ff <= wdata_i & 16'h200f;
            `ADDR_CMP_PRI:  compare_value_ff <= wdata_i;
            `ADDR_CMP_SEC:  cmp_sec_ff <= wdata_i;
            default:        cap_ctrl_ff <= cap_ctrl_ff;
         endcase
      end
   end

   // Read port; data register read pops one capture
   always @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rdata_o <= 16'h0000;
         pop_ff  <= 1'b0;
      end
      else
      begin
         pop_ff  <= rd_i && (addr_i == `ADDR_CAP_DATA);
         rdata_o <= 16'h0000;
         if (rd_i)
         begin
            case (addr_i)
               `ADDR_CAP_CTRL: rdata_o <= cap_ctrl_ff
                  | ({15'h0000, cap_ovf_ff} << `BIT_CAP_OVF)
                  | ({15'h0000, ~fifo_empty} << `BIT_CAP_BNE);
               `ADDR_CAP_DATA: rdata_o <= fifo_empty ? 16'h0000 : fifo_data;
               `ADDR_CMP_CTRL: rdata_o <= cmp_ctrl_ff
                  | ({15'h0000, cmp_flt_ff} << `BIT_CMP_FLT);
               `ADDR_CMP_PRI:  rdata_o <= compare_value_ff;
               `ADDR_CMP_SEC:  rdata_o <= cmp_sec_ff;
               default:        rdata_o <= {13'h0000, fifo_level};
            endcase
         end
      end
   end
endmodule

// >>> sim/capcmp_pins.sv
// Pin-side model: capture signal source and fault source
`timescale 1ns/1ps
module capcmp_pins
(
   input  wire logic clk_sys_i,             // System clock
   output logic      capture_input_pin_o,   // Drives capture pin
   output logic      compare_fault_input_o  // Fault line, idles high
);
   // Pins idle low and high
   initial
   begin
      capture_input_pin_o   = 1'b0;
      compare_fault_input_o = 1'b1;
   end
   // Whole pulses; width in clocks lets a caller be prompt or slow
   task automatic pulse(input int n, input int w = 6);
      repeat (n)
      begin
         repeat (w) @(posedge clk_sys_i);
         capture_input_pin_o <= 1'b1;
         repeat (w) @(posedge clk_sys_i);
         capture_input_pin_o <= 1'b0;
      end
      repeat (w) @(posedge clk_sys_i);
   endtask
   // Falling edge marks a fault, then back to idle
   task automatic fault();
      @(posedge clk_sys_i);
      compare_fault_input_o <= 1'b0;
      repeat (6) @(posedge clk_sys_i);
      compare_fault_input_o <= 1'b1;
   endtask
endmodule

// >>> sim/capture_compare_channels_props.sv
// Port-level assertions for the capture/compare channels
`timescale 1ns/1ps
`include "capcmp_regs.vh"
module capture_compare_channels_props
(
   input wire        clk_sys_i,          // System clock
   input wire        rst_i,              // Async reset
   input wire [3:0]  addr_i,             // Register index
   input wire [15:0] wdata_i,            // Write data
   input wire        wr_i,               // Write strobe
   input wire [15:0] first_time_base_i,  // First timer
   input wire [15:0] second_time_base_i, // Second timer
   input wire        cpu_idle_i,         // CPU idle
   input wire        cpu_sleep_i,        // CPU sleep
   input wire        cap_irq_o,          // Capture interrupt
   input wire        cap_dma_req_o,      // Capture DMA request
   input wire        wake_o,             // Wake pulse
   input wire        cmp_out_o,          // Compare pin
   input wire        cmp_oe_o,           // Compare owns pin
   input wire        cmp_irq_o           // Compare interrupt
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   logic [2:0]  cmod_ff;                 // Compare mode as written
   logic [2:0]  capm_ff;                 // Capture mode as written
   logic [1:0]  cpi_ff;                  // Captures per interrupt
   logic        tsel_ff;                 // Compare timer select
   logic [15:0] cval_ff;                 // Primary compare value
   wire         hit = cval_ff == (tsel_ff ? second_time_base_i : first_time_base_i);
   // Shadow fields from the write port; no read-back needed
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         {cmod_ff, capm_ff, cpi_ff, tsel_ff, cval_ff} <= '0;
      end
      else if (wr_i)
      begin
         if (addr_i == `ADDR_CMP_CTRL) {tsel_ff, cmod_ff} <= wdata_i[3:0];
         if (addr_i == `ADDR_CAP_CTRL) {cpi_ff, capm_ff} <= {wdata_i[6:5], wdata_i[2:0]};
         if (addr_i == `ADDR_CMP_PRI) cval_ff <= wdata_i;
      end
   end
   cmp_off_a: assert property ((cmod_ff == 3'h0)[*3] |-> !cmp_oe_o && !cmp_irq_o)
      else $error("compare active while off");
   match_out_a: assert property (cmod_ff == 3'h1 && $past(cmod_ff, 2) == 3'h1 && hit
      && !cpu_idle_i |=> cmp_out_o) else $error("match did not drive pin high");
   high_shot_a: assert property (cmod_ff == 3'h1 && $past(cmod_ff, 2) == 3'h1
      && $rose(cmp_out_o) |-> cmp_irq_o) else $error("no interrupt on rise");
   low_shot_a: assert property (cmod_ff == 3'h2 && $past(cmod_ff, 2) == 3'h2
      && $fell(cmp_out_o) |-> cmp_irq_o) else $error("no interrupt on fall");
   toggle_irq_a: assert property (cmod_ff == 3'h3 && $past(cmod_ff, 2) == 3'h3
      && $changed(cmp_out_o) |-> cmp_irq_o) else $error("no interrupt on toggle");
   pwm_quiet_a: assert property ((cmod_ff == 3'h6)[*3] |-> !cmp_irq_o)
      else $error("interrupt in plain pwm");
   dma_depth_a: assert property (cap_dma_req_o |-> cpi_ff == 2'b00)
      else $error("dma request with deep buffer");
   cap_off_a: assert property ((capm_ff == 3'h0)[*3] |-> !cap_irq_o && !cap_dma_req_o)
      else $error("capture activity while off");
   wake_src_a: assert property (wake_o |-> $past(cpu_sleep_i || cpu_idle_i))
      else $error("wake while awake");
   sleep_irq_a: assert property (capm_ff == 3'h7 && cap_irq_o
      |-> $past(cpu_sleep_i || cpu_idle_i)) else $error("pin interrupt while awake");
   cover property (cap_dma_req_o);
   cover property (wake_o);
   cover property (cmod_ff == 3'h3 && cmp_irq_o);
endmodule
bind capture_compare_channels capture_compare_channels_props i_props
(
   .clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .first_time_base_i(first_time_base_i), .second_time_base_i(second_time_base_i),
   .cpu_idle_i(cpu_idle_i), .cpu_sleep_i(cpu_sleep_i), .cap_irq_o(cap_irq_o),
   .cap_dma_req_o(cap_dma_req_o), .wake_o(wake_o), .cmp_out_o(cmp_out_o),
   .cmp_oe_o(cmp_oe_o), .cmp_irq_o(cmp_irq_o)
);

// >>> sim/test_capture_compare_channels.sv
// Self-checking bench for the capture/compare channels
`timescale 1ns/1ps
`include "capcmp_regs.vh"
module test_capture_compare_channels;
   logic        clk_sys_i = 1'b0;             // 125 MHz clock
   logic        rst_i = 1'b1;                 // Async reset
   logic [3:0]  addr_i = 4'h0;                // Register index
   logic [15:0] wdata_i = 16'h0000;           // Write data
   logic        wr_i = 1'b0;                  // Write strobe
   logic        rd_i = 1'b0;                  // Read strobe
   logic [15:0] first_time_base_i = 16'h0000; // First timer
   logic [15:0] second_time_base_i = 16'h0000;// Second timer
   logic        cpu_idle_i = 1'b0;            // CPU idle
   logic        cpu_sleep_i = 1'b0;           // CPU sleep
   logic        run_q = 1'b0;                 // First timer counting
   logic [15:0] base_q = 16'h0000;            // First timer load value
   logic        pwm_period_i = 1'b0;          // Period rollover pulse
   wire  [15:0] rdata_o;
   wire         pin, flt, cap_irq_o, cap_dma_req_o, wake_o, cmp_out_o, cmp_oe_o, cmp_irq_o;
   int          error_cnt = 0, compares = 0, cap_n = 0, cmp_n = 0, wake_n = 0, c0;
   logic [15:0] d;
   int          cp [5] = '{1, 3, 2, 8, 16};   // Pulses per capture mode
   logic [15:0] lv [5] = '{16'h0002, 16'h0003, 16'h0002, 16'h0002, 16'h0001};
   int          cm [8] = '{1, 2, 3, 3, 4, 5, 6, 7}; // Compare mode steps
   logic [7:0]  ci = 8'hca;                   // Pin level after entry, per step
   logic [7:0]  cf = 8'h05;                   // Pin level after the run
   int          cq [8] = '{1, 2, 3, 4, 5, 6, 6, 6}; // Running interrupt count
   initial forever #4 clk_sys_i = ~clk_sys_i;
   capture_compare_channels i_dut
   (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .first_time_base_i(first_time_base_i),
      .second_time_base_i(second_time_base_i), .cpu_idle_i(cpu_idle_i),
      .cpu_sleep_i(cpu_sleep_i), .capture_input_pin_i(pin), .compare_fault_input_i(flt),
      .pwm_period_i(pwm_period_i), .cap_irq_o(cap_irq_o), .cap_dma_req_o(cap_dma_req_o),
      .wake_o(wake_o), .cmp_out_o(cmp_out_o), .cmp_oe_o(cmp_oe_o), .cmp_irq_o(cmp_irq_o)
   );
   capcmp_pins i_pins (.clk_sys_i(clk_sys_i), .capture_input_pin_o(pin),
      .compare_fault_input_o(flt));
   // Count one-cycle pulses; a free-running first timer when asked
   always @(posedge clk_sys_i)
   begin
      cap_n  <= cap_n + (cap_irq_o === 1'b1);
      cmp_n  <= cmp_n + (cmp_irq_o === 1'b1);
      wake_n <= wake_n + (wake_o === 1'b1);
      // Single driver of the first timer: count or load
      first_time_base_i <= run_q ? first_time_base_i + 16'h0001 : base_q;
   end
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk_sys_i);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      wr_i    <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      rd_i   <= 1'b0;
      #1 v = rdata_o;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
      rd(a, d);
      chk(d & m, e);
   endtask
   task automatic end_sim();
      if (error_cnt == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Watchdog, far beyond the roughly 1100 cycles needed
   initial
   begin
      repeat (20000) @(posedge clk_sys_i);
      error_cnt++;
      end_sim();
   end
   initial
   begin
      repeat (20) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      rchk(`ADDR_CAP_CTRL, 16'hffff, `CTRL_RESET);
      rchk(`ADDR_CMP_CTRL, 16'hffff, `CTRL_RESET);
      wr(`ADDR_CAP_CTRL, 16'h0018);
      wr(4'h9, 16'hffff);
      rchk(`ADDR_CAP_CTRL, 16'h0018, 16'h0000);
      base_q             <= 16'h1111;
      second_time_base_i <= 16'h2222;
      wr(`ADDR_CAP_CTRL, 16'h00a3);
      i_pins.pulse(1);
      chk(16'(cap_n), 16'h0000);
      base_q <= 16'h3333;
      i_pins.pulse(1, 20);
      chk(16'(cap_n), 16'h0001);
      rchk(`ADDR_CAP_DATA, 16'hffff, 16'h1111);
      rchk(`ADDR_CAP_DATA, 16'hffff, 16'h3333);
      rchk(`ADDR_CAP_CTRL, 16'h0008, 16'h0000);
      wr(`ADDR_CAP_CTRL, 16'h0000);
      wr(`ADDR_CAP_CTRL, 16'h0063);
      for (int k = 0; k < 5; k++)
      begin
         second_time_base_i <= 16'h0a00 + 16'(k);
         i_pins.pulse(1);
      end
      chk(16'(cap_n), 16'h0002);
      rchk(`ADDR_CAP_CTRL, 16'h0018, 16'h0018);
      for (int k = 0; k < 4; k++) rchk(`ADDR_CAP_DATA, 16'hffff, 16'h0a00 + 16'(k));
      // Overflow clears one cycle after the last pop empties the buffer
      @(posedge clk_sys_i);
      rchk(`ADDR_CAP_CTRL, 16'h0018, 16'h0000);
      wr(`ADDR_CAP_CTRL, 16'h0000);
      wr(`ADDR_CAP_CTRL, 16'h0061);
      i_pins.pulse(1);
      chk(16'(cap_n), 16'h0004);
      for (int k = 0; k < 5; k++)
      begin
         wr(`ADDR_CAP_CTRL, 16'h0000);
         wr(`ADDR_CAP_CTRL, 16'(k + 1));
         i_pins.pulse(cp[k]);
         rchk(4'h5, 16'h0007, lv[k]);
      end
      wr(`ADDR_CAP_CTRL, 16'h0000);
      wr(`ADDR_CAP_CTRL, 16'h0007);
      c0 = cap_n;
      i_pins.pulse(1);
      cpu_sleep_i <= 1'b1;
      i_pins.pulse(1);
      cpu_sleep_i <= 1'b0;
      chk(16'(cap_n - c0), 16'h0001);
      chk(16'(wake_n), 16'h0001);
      wr(`ADDR_CAP_CTRL, 16'h0000);
      wr(`ADDR_CAP_CTRL, 16'h2003);
      cpu_idle_i <= 1'b1;
      i_pins.pulse(1);
      cpu_idle_i <= 1'b0;
      rchk(4'h5, 16'h0007, 16'h0000);
      i_pins.pulse(1);
      rchk(4'h5, 16'h0007, 16'h0001);
      wr(`ADDR_CMP_PRI, 16'h0010);
      wr(`ADDR_CMP_SEC, 16'h0020);
      for (int k = 0; k < 8; k++)
      begin
         run_q <= 1'b0;
         base_q <= 16'h0000;
         wr(`ADDR_CMP_CTRL, 16'(cm[k]));
         repeat (2) @(posedge clk_sys_i);
         #1 chk({15'h0, cmp_out_o}, {15'h0, ci[k]});
         run_q <= 1'b1;
         repeat (40) @(posedge clk_sys_i);
         #1 chk({15'h0, cmp_out_o}, {15'h0, cf[k]});
         chk(16'(cmp_n), 16'(cq[k]));
      end
      pwm_period_i <= 1'b1;
      @(posedge clk_sys_i);
      pwm_period_i <= 1'b0;
      @(posedge clk_sys_i);
      #1 chk({15'h0, cmp_out_o}, 16'h0001);
      i_pins.fault();
      repeat (8) @(posedge clk_sys_i);
      #1 chk({15'h0, cmp_out_o}, 16'h0000);
      rchk(`ADDR_CMP_CTRL, 16'h0010, 16'h0010);
      chk(16'(cmp_n), 16'h0007);
      wr(`ADDR_CMP_CTRL, 16'h0000);
      repeat (3) @(posedge clk_sys_i);
      #1 chk({15'h0, cmp_oe_o}, 16'h0000);
      end_sim();
   end
endmodule
